// file: hw/olsa_top.sv
// Purpose: Drives panel indicators from selected operands and serves packed state words.
// Assumes: All inputs except i_nrst synchronous to i_clk; configuration held stable by its owner.
// Notes:   A read is answered one cycle after i_rd_en with a single-cycle snapshot.
module olsa_top (
  input  wire logic                                          i_clk,
  input  wire logic                                          i_nrst,
  input  wire logic [olsa_pkg::OPERAND_COUNT-1:0]            i_operands,
  input  wire logic [olsa_pkg::PROG_IND_COUNT*olsa_pkg::SEL_W-1:0] i_indicator_source_select,
  input  wire logic [olsa_pkg::PROG_IND_COUNT-1:0]           i_indicator_mode_select,
  input  wire logic [olsa_pkg::SEL_W-1:0]                    i_trip_source_select,
  input  wire logic                                          i_trip_mode_select,
  input  wire logic [olsa_pkg::SEL_W-1:0]                    i_alarm_source_select,
  input  wire logic                                          i_alarm_mode_select,
  input  wire logic                                          i_panel_reset,
  input  wire logic                                          i_comm_reset,
  input  wire logic [olsa_pkg::SEL_W-1:0]                    i_reset_source_select,
  input  wire logic [olsa_pkg::SLOT_COUNT*olsa_pkg::SEL_W-1:0]     i_slot_source_select,
  input  wire logic                                          i_rd_en,
  input  wire logic [olsa_pkg::ADDR_W-1:0]                   i_rd_addr,
  output logic                                               o_trip,
  output logic                                               o_alarm,
  output logic [olsa_pkg::GROUP_IND_COUNT-1:0]               o_panel2,
  output logic [olsa_pkg::GROUP_IND_COUNT-1:0]               o_panel3,
  output logic [olsa_pkg::WORD_W-1:0]                        o_rd_data,
  output logic                                               o_rd_valid,
  output logic                                               o_rd_err
);
  import olsa_pkg::*;

  // ----------------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------------
  // Code zero selects nothing, so operand bit zero can never light anything.
  function automatic logic pick(input logic [OPERAND_COUNT-1:0] ops,
                                input logic [SEL_W-1:0]         sel);
    logic r;
    r = 1'b0;
    if (sel != SEL_OFF) begin
      r = ops[sel];
    end
    return r;
  endfunction

  // Returns the operand code chosen for programmable indicator n, counted from zero.
  function automatic logic [SEL_W-1:0] prog_source(
      input logic [PROG_IND_COUNT*SEL_W-1:0] sels,
      input int                              n);
    logic [SEL_W-1:0] r;
    r = sels[n*SEL_W +: SEL_W];
    return r;
  endfunction

  // Returns the operand code chosen for state slot s, counted from zero.
  function automatic logic [SEL_W-1:0] slot_source(
      input logic [SLOT_COUNT*SEL_W-1:0] sels,
      input int                          s);
    logic [SEL_W-1:0] r;
    r = sels[s*SEL_W +: SEL_W];
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Indicator update
  // ----------------------------------------------------------------------
  // The three clear sources are levels; any one of them clears every latch.
  function automatic logic any_clear(input logic                     panel,
                                     input logic                     comm,
                                     input logic [OPERAND_COUNT-1:0] ops,
                                     input logic [SEL_W-1:0]         sel);
    logic r;
    r = panel | comm | pick(ops, sel);
    return r;
  endfunction

  // A set in the same cycle as a clear wins, so a held operand keeps its indicator lit.
  function automatic logic update_lit(input logic mode,
                                      input logic op,
                                      input logic lit,
                                      input logic clr);
    logic r;
    r = op;
    if (mode == MODE_LATCHED) begin
      r = op | (lit & ~clr);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // State word decode
  // ----------------------------------------------------------------------
  // True for an address inside the packed state words; all others are refused.
  function automatic logic word_hit(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] offs;
    logic              r;
    offs = addr - STATE_WORDS_BASE;
    r    = (addr >= STATE_WORDS_BASE) && (offs < ADDR_W'(WORD_COUNT));
    return r;
  endfunction

  // Gives the word number within the packed state words.
  function automatic logic [WORD_IDX_W-1:0] word_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] offs;
    offs = addr - STATE_WORDS_BASE;
    return offs[WORD_IDX_W-1:0];
  endfunction

  // Packs sixteen slots into one word, the lowest-numbered slot at bit zero.
  function automatic logic [WORD_W-1:0] pack_word(
      input logic [OPERAND_COUNT-1:0]    ops,
      input logic [SLOT_COUNT*SEL_W-1:0] sels,
      input logic [WORD_IDX_W-1:0]       widx);
    logic [WORD_W-1:0] r;
    int                slot;
    r    = STATE_WORD_RESET;
    slot = 0;
    for (int b = 0; b < WORD_W; b++) begin
      slot = int'(widx) * WORD_W + b;
      r[b] = pick(ops, slot_source(sels, slot));
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  // Reset asserts at once but leaves through two flops, so no flop sees a torn release.
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Every output is a field of this register, so no output passes through logic.
  olsa_state_s state;
  olsa_state_s next_state;

  localparam olsa_state_s STATE_RESET = '{
    lit:      LIT_RESET,
    rd_data:  STATE_WORD_RESET,
    rd_valid: 1'b0,
    rd_err:   1'b0
  };

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic                  clear_all;
    logic                  op;
    logic                  hit;
    logic [WORD_IDX_W-1:0] widx;
    logic [WORD_W-1:0]     word;
    clear_all  = 1'b0;
    op         = 1'b0;
    hit        = 1'b0;
    widx       = '0;
    word       = STATE_WORD_RESET;
    next_state = state;

    clear_all = any_clear(i_panel_reset, i_comm_reset,
                          i_operands, i_reset_source_select);

    // Programmable indicators feed panel groups two and three.
    for (int i = 0; i < PROG_IND_COUNT; i++) begin
      op = pick(i_operands, prog_source(i_indicator_source_select, i));
      next_state.lit[i] = update_lit(i_indicator_mode_select[i], op,
                                     state.lit[i], clear_all);
    end

    // Trip and alarm sit in panel group one with their own selects.
    op = pick(i_operands, i_trip_source_select);
    next_state.lit[TRIP_IDX] = update_lit(i_trip_mode_select, op,
                                          state.lit[TRIP_IDX], clear_all);
    op = pick(i_operands, i_alarm_source_select);
    next_state.lit[ALARM_IDX] = update_lit(i_alarm_mode_select, op,
                                           state.lit[ALARM_IDX], clear_all);

    // A read takes its snapshot at the request edge and answers one cycle later.
    hit  = word_hit(i_rd_addr);
    widx = word_index(i_rd_addr);
    word = pack_word(i_operands, i_slot_source_select, widx);
    next_state.rd_valid = i_rd_en;
    next_state.rd_err   = 1'b0;
    if (i_rd_en) begin
      if (hit) begin
        next_state.rd_data = word;
      end else begin
        next_state.rd_data = STATE_WORD_RESET;
        next_state.rd_err  = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_panel2   = state.lit[GROUP_IND_COUNT-1:0];
  assign o_panel3   = state.lit[PROG_IND_COUNT-1:GROUP_IND_COUNT];
  assign o_trip     = state.lit[TRIP_IDX];
  assign o_alarm    = state.lit[ALARM_IDX];
  assign o_rd_data  = state.rd_data;
  assign o_rd_valid = state.rd_valid;
  assign o_rd_err   = state.rd_err;

endmodule

// file: pkg/olsa_pkg.sv
// Purpose: Constants and types for the operand indicator and packed state array block.
// Assumes: Operands arrive as one 256-bit vector; select code zero means no operand.
// Notes:   All figures used by the logic are named here.
// Contract
// - Each programmable indicator lights while its selected operand is one.
// - Forty-eight amber indicators, each with own source and mode select.
// - Indicators 1-24 drive panel group two, 25-48 drive panel group three.
// - Trip and alarm indicators sit in group one with selectable operands.
// - Tracking mode is default; output follows operand and darkens immediately.
// - Latched mode holds lit until panel, comms or operand reset.
// - State array has 256 slots, each mapped to any operand.
// - Sixteen slot states are packed into each register.
// - Packed registers sit at consecutive addresses from base 900 hex.
// - Lowest-numbered slot occupies bit zero, higher slots higher bits.
// - Exactly sixteen registers cover all 256 slot bits.
package olsa_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int OPERAND_COUNT   = 256;
  localparam int SEL_W           = 8;
  localparam int PROG_IND_COUNT  = 48;
  localparam int GROUP_IND_COUNT = 24;
  localparam int IND_COUNT       = 50;
  localparam int TRIP_IDX        = 48;
  localparam int ALARM_IDX       = 49;
  localparam int SLOT_COUNT      = 256;
  localparam int WORD_W          = 16;
  localparam int WORD_COUNT      = 16;
  localparam int WORD_IDX_W      = 4;
  localparam int ADDR_W          = 16;

  // ----------------------------------------------------------------------
  // Register map and encodings
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] STATE_WORDS_BASE  = 16'h0900;
  localparam logic [SEL_W-1:0]  SEL_OFF           = 8'h00;
  localparam logic              MODE_TRACKING     = 1'h0;
  localparam logic              MODE_LATCHED      = 1'h1;
  localparam logic [WORD_W-1:0] STATE_WORD_RESET  = 16'h0000;
  localparam logic [IND_COUNT-1:0] LIT_RESET      = 50'h0;

  typedef struct packed {
    logic [IND_COUNT-1:0] lit;
    logic [WORD_W-1:0]    rd_data;
    logic                 rd_valid;
    logic                 rd_err;
  } olsa_state_s;

endpackage

// file: sim/olsa_top_properties.sv
// Purpose: Checker for the indicator and state word ports.
// Assumes: Bound to olsa_top; idle until three edges after reset release.
// Notes:   Indicators 1 and 25 and trip stand for their groups.
module olsa_top_props (
  input wire logic          i_clk, i_nrst, i_rd_en, i_panel_reset, i_comm_reset,
  input wire logic          i_trip_mode_select, o_trip, o_rd_valid, o_rd_err,
  input wire logic [255:0]  i_operands,
  input wire logic [383:0]  i_indicator_source_select,
  input wire logic [47:0]   i_indicator_mode_select,
  input wire logic [7:0]    i_trip_source_select, i_reset_source_select,
  input wire logic [2047:0] i_slot_source_select,
  input wire logic [15:0]   i_rd_addr, o_rd_data,
  input wire logic [23:0]   o_panel2, o_panel3);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  rc;
  logic [15:0] ew;
  logic        t1, t25, tt, clr;
  function automatic logic pick(logic [7:0] s, logic [255:0] v);
    return |s & v[s];
  endfunction
  always_ff @(posedge i_clk or negedge i_nrst) if (!i_nrst) rc <= 2'h0;
    else if (rc != 2'h3) rc <= rc + 2'h1;
  assign t1  = pick(i_indicator_source_select[7:0], i_operands);
  assign t25 = pick(i_indicator_source_select[199:192], i_operands);
  assign tt  = pick(i_trip_source_select, i_operands);
  assign clr = i_panel_reset | i_comm_reset | pick(i_reset_source_select, i_operands);
  always_comb for (int b = 0; b < 16; b++)
    ew[b] = pick(i_slot_source_select[{i_rd_addr[3:0], b[3:0]}*8 +: 8], i_operands);
  default clocking @(posedge i_clk); endclocking
  default disable iff (rc != 2'h3);
  track_follow_a: assert property (!i_indicator_mode_select[0] |=> o_panel2[0] == $past(t1))
    else $error("indicator does not track");
  latch_hold_a: assert property (i_indicator_mode_select[0] && o_panel2[0] && !clr |=> o_panel2[0])
    else $error("latched indicator dropped");
  latch_clear_a: assert property (i_indicator_mode_select[0] && clr && !t1 |=> !o_panel2[0])
    else $error("latched indicator not cleared");
  group_three_a: assert property (!i_indicator_mode_select[24] |=> o_panel3[0] == $past(t25))
    else $error("group three indicator wrong");
  trip_follow_a: assert property (!i_trip_mode_select |=> o_trip == $past(tt))
    else $error("trip indicator wrong");
  rd_answer_a: assert property (i_rd_en |=> o_rd_valid)
    else $error("read not answered");
  rd_unmapped_a: assert property (i_rd_en && i_rd_addr[15:4] != 12'h090 |=> o_rd_err && o_rd_data == 16'h0000)
    else $error("unmapped read not flagged");
  rd_word_a: assert property (i_rd_en && i_rd_addr[15:4] == 12'h090 |=> !o_rd_err && o_rd_data == $past(ew))
    else $error("state word wrong");
  cover property (o_rd_err);
  cover property (i_indicator_mode_select[0] && clr && o_panel2[0]);
  cover property (o_rd_valid && o_rd_data != 16'h0000);
endmodule
bind olsa_top olsa_top_props u_props (
  .i_clk                     (i_clk),
  .i_nrst                    (i_nrst),
  .i_rd_en                   (i_rd_en),
  .i_panel_reset             (i_panel_reset),
  .i_comm_reset              (i_comm_reset),
  .i_trip_mode_select        (i_trip_mode_select),
  .o_trip                    (o_trip),
  .o_rd_valid                (o_rd_valid),
  .o_rd_err                  (o_rd_err),
  .i_operands                (i_operands),
  .i_indicator_source_select (i_indicator_source_select),
  .i_indicator_mode_select   (i_indicator_mode_select),
  .i_trip_source_select      (i_trip_source_select),
  .i_reset_source_select     (i_reset_source_select),
  .i_slot_source_select      (i_slot_source_select),
  .i_rd_addr                 (i_rd_addr),
  .o_rd_data                 (o_rd_data),
  .o_panel2                  (o_panel2),
  .o_panel3                  (o_panel3)
);

// file: sim/olsa_master.sv
// Purpose: Polling master that reads one packed state word at a time.
// Assumes: The block answers one cycle after it takes the request.
// Notes:   The released address shows the inverse of the last value.
module olsa_master (
  input  wire logic        i_clk, i_rd_valid, i_rd_err,
  input  wire logic [15:0] i_rd_data,
  output logic             o_rd_en,
  output logic [15:0]      o_rd_addr);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_rd_en = 1'b0;
    o_rd_addr = 16'h0000;
  end
  task automatic poll(input logic [15:0] a, output logic [15:0] d, output logic e, output bit ok);
    ok = 1'b0;
    @(posedge i_clk) {o_rd_en, o_rd_addr} <= {1'b1, a};
    @(posedge i_clk) {o_rd_en, o_rd_addr} <= {1'b0, ~a};
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge i_clk);
      {ok, e, d} = {i_rd_valid === 1'b1, i_rd_err, i_rd_data};
    end
  endtask
endmodule

// file: sim/olsa_top_tb_top.sv
// Purpose: Self-checking bench for the indicator and state word block.
// Assumes: Operand code n selects operand n; code FF is the clear operand.
// Notes:   Inputs change by non-blocking assignment at the rising edge.
module olsa_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk, nrst, tm, am, pr, cr, rd_en, valid, err, trip, alarm, e;
  logic [255:0]  ops;
  logic [383:0]  isel;
  logic [47:0]   mode;
  logic [2047:0] ssel;
  logic [23:0]   p2, p3;
  logic [15:0]   addr, data, d;
  logic [7:0]    tsel, asel, rsel;
  bit            ok;
  int            bad_count, checks;
  olsa_top dut (.i_clk(clk), .i_nrst(nrst), .i_operands(ops), .i_indicator_source_select(isel),
    .i_indicator_mode_select(mode), .i_trip_source_select(tsel), .i_trip_mode_select(tm),
    .i_alarm_source_select(asel), .i_alarm_mode_select(am), .i_panel_reset(pr),
    .i_comm_reset(cr), .i_reset_source_select(rsel), .i_slot_source_select(ssel),
    .i_rd_en(rd_en), .i_rd_addr(addr), .o_trip(trip), .o_alarm(alarm), .o_panel2(p2),
    .o_panel3(p3), .o_rd_data(data), .o_rd_valid(valid), .o_rd_err(err));
  olsa_master m (.i_clk(clk), .i_rd_valid(valid), .i_rd_err(err), .i_rd_data(data),
    .o_rd_en(rd_en), .o_rd_addr(addr));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [63:0] g, w);
    checks++;
    if (g !== w) begin
      bad_count++;
      $display("unexpected at %0t: got %0h want %0h", $time, g, w);
    end
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {nrst, ops, mode, pr, cr, tm, am} = '0;
    for (int n = 0; n < 48; n++) isel[n*8 +: 8] = 8'(n + 1);
    for (int s = 0; s < 256; s++) ssel[s*8 +: 8] = 8'(s);
    {tsel, asel, rsel} = 24'h3132FF;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      ops <= k ? 256'h0 : {8{32'h6A5C_93E7}};
      repeat (2) @(posedge clk);
      chk({alarm, trip, p3, p2}, ops[50:1]);
    end
    {mode, tm, am} <= '1;
    for (int k = 0; k < 3; k++) begin
      ops <= 256'h7_FFFF_FFFF_FFFE;
      @(posedge clk) ops <= 256'h0;
      repeat (2) @(posedge clk);
      chk({alarm, trip, p3, p2}, 50'h3_FFFF_FFFF_FFFF);
      {pr, cr, ops[255]} <= {k == 0, k == 1, k == 2};
      @(posedge clk) {pr, cr, ops[255]} <= '0;
      @(posedge clk);
      chk({alarm, trip, p3, p2}, 0);
    end
    ops <= {8{32'hC3A5_1E69}};
    for (int w = 0; w < 18; w++) begin
      m.poll(w == 17 ? 16'h08FF : 16'(16'h0900 + w), d, e, ok);
      if (!ok) begin
        bad_count++;
        $display("unexpected at %0t: read not answered", $time);
        break;
      end
      chk({e, d}, w < 16 ? {1'b0, ops[w*16 +: 16] & {15'h7FFF, w != 0}} : 17'h10000);
    end
    wrap_up;
  end
endmodule
